// *** hdl/sfw_top.sv ***
// Command, protection and write sequencing for a serial flash.
// Assumes an external array: combinational read port used from the SPI
// clock domain, byte write and sector-map erase strobes on clk_i.
`timescale 1ns/1ps
`default_nettype none
module sfw_top
  import sfw_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = PROG_CYC,
  parameter int unsigned SECT_CYCLES = SECT_CYC,
  parameter int unsigned CHIP_CYCLES = CHIP_CYC,
  parameter int unsigned SRWR_CYCLES = SRWR_CYC
)
(
  // Core clock and reset
  input  wire logic              clk_i,
  input  wire logic              arst_n_i,
  // SPI link
  input  wire logic              sck_i,
  input  wire logic              cs_n_i,
  input  wire logic              si_i,
  output logic                   so_o,
  output logic                   so_oe_o,
  // Write protect pin
  input  wire logic              wp_n_i,
  // Array read port, SPI clock domain
  output logic [ADDR_W-1:0]      mem_raddr_o,
  input  wire logic [7:0]        mem_rdata_i,
  // Array write port, core clock domain
  output logic                   mem_we_o,
  output logic [ADDR_W-1:0]      mem_waddr_o,
  output logic [7:0]             mem_wdata_o,
  output logic                   mem_erase_o,
  output logic [7:0]             mem_erase_map_o,
  // Status
  output logic [7:0]             status_o,
  output logic                   busy_o
);
  // ===========================================================
  // Link domain: frame counters and shifting
  logic              lnk_rst_n;        // Frame reset: chip select high
  logic [2:0]        bit_cnt;          // Bit within current byte
  logic [2:0]        byte_cnt;         // Completed bytes, saturating
  logic [6:0]        shreg;            // Incoming bits
  logic [7:0]        op;               // Opcode of this frame
  logic [ADDR_W-1:0] addr;             // Read address counter
  logic [7:0]        col;              // Page column for program data
  logic [7:0]        rx_byte;          // Byte completing on this edge
  logic              byte_done;        // Last bit of a byte arrives
  logic [7:0]        op_m;             // Opcode with bit 3 masked
  logic [7:0]        rx_m;             // Incoming byte with bit 3 masked
  logic [7:0]        st_q1;            // Status byte sync, first stage
  logic [7:0]        st_q2;            // Status byte sync, second stage
  logic [6:0]        txs;              // Outgoing bits
  logic              tx_en;            // Frame is answering
  logic [7:0]        tx_src;           // Byte loaded at byte boundary
  // Frame results, held after chip select rises
  logic [7:0]        fr_op;
  logic [ADDR_W-1:0] fr_addr;
  logic [7:0]        fr_data;
  logic [2:0]        fr_cnt;
  logic              fr_part;          // Frame ended mid-byte
  logic [7:0]        pbuf [256];       // Page buffer
  logic [255:0]      pval;             // Page bytes supplied

  // Chip select high holds the frame parser and output shifter in reset
  assign lnk_rst_n = arst_n_i & ~cs_n_i;
  assign rx_byte   = {shreg, si_i};
  assign byte_done = (bit_cnt == 3'd7);
  assign op_m      = op & OP_MASK;
  assign rx_m      = rx_byte & OP_MASK;
  assign mem_raddr_o = addr;

  // Frame parser: sample on rising edge, MSB first
  always_ff @(posedge sck_i or negedge lnk_rst_n)
  begin
    if (!lnk_rst_n)
    begin
      bit_cnt  <= 3'd0;
      byte_cnt <= 3'd0;
      shreg    <= 7'h00;
      op       <= 8'h00;
      addr     <= '0;
      col      <= 8'h00;
    end
    else
    begin
      bit_cnt <= bit_cnt + 3'd1;
      shreg   <= {shreg[5:0], si_i};
      if (byte_done)
      begin
        if (byte_cnt != BYTE_SAT)
          byte_cnt <= byte_cnt + 3'd1;
        case (byte_cnt)
          3'd0: op <= rx_byte;
          // Upper address bits beyond 18 are dropped
          3'd1: addr[18:16] <= rx_byte[2:0];
          3'd2: addr[15:8] <= rx_byte;
          3'd3:
          begin
            addr[7:0] <= rx_byte;
            col       <= rx_byte;
          end
          default:
          begin
            addr <= addr + 19'd1;
            col  <= col + 8'd1;
          end
        endcase
      end
    end
  end

  // Status byte from the core; quasi-static, refreshed every rising SCK
  // edge of the frame. A busy end mid-opcode may show one torn byte.
  always_ff @(posedge sck_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      st_q1 <= 8'h00;
      st_q2 <= 8'h00;
    end
    else
    begin
      st_q1 <= status_o;
      st_q2 <= st_q1;
    end
  end

  // Answer source: status repeats, read streams the array
  always_comb
  begin
    tx_en  = 1'b0;
    tx_src = st_q2;
    if (op_m == OP_STAT_READ && byte_cnt != 3'd0)
      tx_en = 1'b1;
    else if (op_m == OP_READ && byte_cnt >= 3'd4 && !st_q2[0])
    begin
      tx_en  = 1'b1;
      tx_src = mem_rdata_i;
    end
  end

  // Output shifter: change on falling edge, new byte at boundary
  always_ff @(negedge sck_i or negedge lnk_rst_n)
  begin
    if (!lnk_rst_n)
    begin
      so_o    <= 1'b0;
      so_oe_o <= 1'b0;
      txs     <= 7'h00;
    end
    else if (bit_cnt == 3'd0)
    begin
      so_o    <= tx_src[7];
      txs     <= tx_src[6:0];
      so_oe_o <= tx_en;
    end
    else
    begin
      so_o <= txs[6];
      txs  <= {txs[5:0], 1'b0};
    end
  end

  // Frame results survive chip select; the core reads them once it
  // has seen chip select high, and a program walk keeps reading fr_addr and pval while later frames clock SCK.
  always_ff @(posedge sck_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      fr_op   <= 8'h00;
      fr_addr <= '0;
      fr_data <= 8'h00;
      fr_cnt  <= 3'd0;
      fr_part <= 1'b0;
      pval    <= '0;
    end
    else
    begin
      fr_part <= !byte_done;
      if (byte_done && byte_cnt != BYTE_SAT)
        fr_cnt <= byte_cnt + 3'd1;
      else
        fr_cnt <= byte_cnt;
      if (byte_done && byte_cnt == 3'd0)
      begin
        fr_op <= rx_byte;
        // A program opcode sent while busy must not wipe the page being walked
        if (rx_m == OP_PROGRAM && !st_q2[0])
          pval <= '0;
      end
      if (byte_done && byte_cnt == 3'd1)
        fr_data <= rx_byte;
      if (byte_done && byte_cnt == 3'd3)
        fr_addr <= {addr[18:8], rx_byte};
      if (byte_done && byte_cnt >= 3'd4 && op_m == OP_PROGRAM && !st_q2[0])
        pval[col] <= 1'b1;
    end
  end

  // Page data; later bytes at a wrapped column replace earlier ones
  always_ff @(posedge sck_i)
  begin
    if (byte_done && byte_cnt >= 3'd4 && op_m == OP_PROGRAM && !st_q2[0])
      pbuf[col] <= rx_byte;
  end

  // ===========================================================
  // Core domain: reset release and pin synchronisers
  logic       rst_q1;
  logic       rst_n;                           // Released reset
  logic       cs_q1;
  logic       cs_q2;
  logic       cs_q3;
  logic       wp_q1;
  logic       wp_q2;
  logic       frame_end;                       // Chip select rose
  logic       hw_prot;                         // Hardware protect active
  logic [7:0] lock;                            // Locked sectors
  logic [7:0] fr_m;                            // Frame opcode, masked
  logic       wr_ok;                           // Write frame well formed
  sfw_state_e state;                           // Sequencer state
  logic       wel;                             // Write enable latch
  logic [2:0] lvl;                             // Protect level
  logic       hpe;                             // Hardware protect enable
  logic [7:0] new_stat;                        // Pending status value
  logic [31:0] timer;                          // Self-timed cycle counter
  logic [8:0] idx;                             // Page scan index

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rst_q1 <= 1'b0;
      rst_n  <= 1'b0;
    end
    else
    begin
      rst_q1 <= 1'b1;
      rst_n  <= rst_q1;
    end
  end

  // Chip select and protect pin cross in through two flops
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cs_q1 <= 1'b1;
      cs_q2 <= 1'b1;
      cs_q3 <= 1'b1;
      wp_q1 <= 1'b1;
      wp_q2 <= 1'b1;
    end
    else
    begin
      cs_q1 <= cs_n_i;
      cs_q2 <= cs_q1;
      cs_q3 <= cs_q2;
      wp_q1 <= wp_n_i;
      wp_q2 <= wp_q1;
    end
  end

  assign frame_end = cs_q2 & ~cs_q3;
  // Taken from the bit itself: status_o still reads all ones for one
  // cycle after a busy cycle ends and would hide the protection there
  assign hw_prot   = ~wp_q2 & hpe;
  assign lock      = sfw_lock_map(lvl);
  assign fr_m      = fr_op & OP_MASK;
  assign wr_ok     = wel & ~fr_part;

  // ===========================================================
  // Sequencer

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state           <= SFW_IDLE;
      wel             <= 1'b0;
      lvl             <= 3'd0;
      hpe             <= 1'b0;
      new_stat        <= 8'h00;
      timer           <= 32'h0;
      idx             <= 9'h000;
      mem_we_o        <= 1'b0;
      mem_waddr_o     <= '0;
      mem_wdata_o     <= 8'h00;
      mem_erase_o     <= 1'b0;
      mem_erase_map_o <= 8'h00;
    end
    else
    begin
      mem_we_o    <= 1'b0;
      mem_erase_o <= 1'b0;
      case (state)
        // Commands act only once the frame has ended
        SFW_IDLE:
        begin
          if (frame_end && fr_cnt != 3'd0)
          begin
            case (fr_m)
              OP_SET_LATCH:  wel <= 1'b1;
              OP_CLR_LATCH:  wel <= 1'b0;
              OP_STAT_WRITE:
                // Refused without latch or under hardware protect
                if (wr_ok && !hw_prot && fr_cnt >= 3'd2)
                begin
                  new_stat <= fr_data;
                  timer    <= SRWR_CYCLES - 32'd1;
                  state    <= SFW_SRWAIT;
                end
              OP_PROGRAM:
                if (wr_ok && fr_cnt == BYTE_SAT)
                begin
                  idx   <= 9'h000;
                  state <= SFW_SCAN;
                end
              OP_SECT_ERASE:
                if (wr_ok && fr_cnt >= 3'd4 && !lock[fr_addr[18:16]])
                begin
                  mem_erase_o     <= 1'b1;
                  mem_erase_map_o <= 8'h01 << fr_addr[18:16];
                  timer           <= SECT_CYCLES - 32'd1;
                  state           <= SFW_EWAIT;
                end
              OP_CHIP_ERASE:
                if (wr_ok)
                begin
                  mem_erase_o     <= 1'b1;
                  mem_erase_map_o <= ~lock;
                  timer           <= CHIP_CYCLES - 32'd1;
                  state           <= SFW_EWAIT;
                end
              default:
              begin
                // Reads are served in the link domain; others dropped
              end
            endcase
          end
        end
        // New protect bits take effect only at cycle end
        SFW_SRWAIT:
        begin
          if (timer == 32'h0)
          begin
            lvl   <= new_stat[STAT_LVL_LSB +: 3];
            hpe   <= new_stat[STAT_HPE_BIT];
            wel   <= 1'b0;
            state <= SFW_IDLE;
          end
          else
            timer <= timer - 32'd1;
        end
        // Walk the page; only supplied, unlocked bytes are written
        SFW_SCAN:
        begin
          if (idx[8])
          begin
            wel   <= 1'b0;
            state <= SFW_IDLE;
          end
          else
          begin
            idx <= idx + 9'd1;
            if (pval[idx[7:0]] && !lock[fr_addr[18:16]])
            begin
              mem_we_o    <= 1'b1;
              mem_waddr_o <= {fr_addr[18:8], idx[7:0]};
              mem_wdata_o <= pbuf[idx[7:0]];
              timer       <= PROG_CYCLES - 32'd1;
              state       <= SFW_PWAIT;
            end
          end
        end
        SFW_PWAIT:
        begin
          if (timer == 32'h0)
            state <= SFW_SCAN;
          else
            timer <= timer - 32'd1;
        end
        SFW_EWAIT:
        begin
          if (timer == 32'h0)
          begin
            wel   <= 1'b0;
            state <= SFW_IDLE;
          end
          else
            timer <= timer - 32'd1;
        end
        default:
          state <= SFW_IDLE;
      endcase
    end
  end

  // Status byte; all ones while any internal cycle runs
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      status_o <= 8'h00;
      busy_o   <= 1'b0;
    end
    else if (state != SFW_IDLE)
    begin
      status_o <= STAT_BUSY_ALL;
      busy_o   <= 1'b1;
    end
    else
    begin
      status_o <= {hpe, 2'b00, lvl, wel, 1'b0};
      busy_o   <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** hdl/sfw_pkg.sv ***
// Constants, opcodes and protection map for the serial flash sequencer.
// Assumes a 200 MHz core clock; SPI link runs in mode 0 on its own clock.
//
// How it works
// - Hardware protect: pin low and enable set
// - Hardware protect blocks status and locked writes
// - Status write is a self-timed cycle
// - Busy cycle ignores all but status read; a frame's address bytes still retarget a program walk
// - Each write cycle end clears latch
// - Protected enable bit cannot be cleared
// - Latch and protection combine per table
// - Read shifts addressed byte out, MSB first
// - Read address increments and wraps to zero
// - Only address bits 18..0 are used
// - Programming starts only after chip select rises
// - Locked bytes are never programmed
// - Status bit 0 shows busy
// - Program wraps inside one 256-byte page
// - Extra bytes overwrite; unsent bytes keep contents
// - Write without latch is discarded
// - Sector erase clears unlocked 64 KB sector
// - Chip erase clears unlocked sectors, self-timed
// - Opcodes decoded with bit 3 ignored
// - All fields travel MSB first
// - Status byte layout; all ones while busy
// - Protect level selects locked top range
package sfw_pkg;
  // ===========================================================
  // Opcodes, compared after masking bit 3
  localparam logic [7:0] OP_MASK       = 8'hF7;
  localparam logic [7:0] OP_SET_LATCH  = 8'h06;
  localparam logic [7:0] OP_CLR_LATCH  = 8'h04;
  localparam logic [7:0] OP_STAT_READ  = 8'h05;
  localparam logic [7:0] OP_STAT_WRITE = 8'h01;
  localparam logic [7:0] OP_READ       = 8'h03;
  localparam logic [7:0] OP_PROGRAM    = 8'h02;
  localparam logic [7:0] OP_SECT_ERASE = 8'h52;
  localparam logic [7:0] OP_CHIP_ERASE = 8'h62;
  // ===========================================================
  // Geometry and status byte layout
  localparam int         ADDR_W        = 19;
  localparam logic [7:0] STAT_BUSY_ALL = 8'hFF;
  localparam int         STAT_HPE_BIT  = 7;
  localparam int         STAT_LVL_LSB  = 2;
  localparam logic [2:0] BYTE_SAT      = 3'd5;
  // ===========================================================
  // Cycle timing
  localparam int unsigned CLK_MHZ    = 200;
  localparam int unsigned T_PROG_NS  = 30000;
  localparam int unsigned T_SECT_MS  = 1000;
  localparam int unsigned T_CHIP_MS  = 8000;
  localparam int unsigned T_SRWR_US  = 15000;
  localparam int unsigned PROG_CYC   = (T_PROG_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SECT_CYC   = T_SECT_MS * CLK_MHZ * 1000;
  localparam int unsigned CHIP_CYC   = T_CHIP_MS * CLK_MHZ * 1000;
  localparam int unsigned SRWR_CYC   = T_SRWR_US * CLK_MHZ;

  // Locked sectors per protect level, bit n for sector n
  function automatic logic [7:0] sfw_lock_map(input logic [2:0] lvl);
    logic [7:0] m;
    m = 8'h00;
    if (lvl[2])
      m = 8'hFF;
    else if (lvl == 3'b001)
      m = 8'h80;
    else if (lvl == 3'b010)
      m = 8'hC0;
    else if (lvl == 3'b011)
      m = 8'hF0;
    return m;
  endfunction

  typedef enum logic [2:0] {
    SFW_IDLE,
    SFW_SRWAIT,
    SFW_SCAN,
    SFW_PWAIT,
    SFW_EWAIT
  } sfw_state_e;
endpackage

// *** tb/sfw_top_monitor.sv ***
// Port-level checker for the flash sequencer top.
// Assumes it is bound into sfw_top and samples on the core clock only.
`timescale 1ns/1ps
`default_nettype none
module sfw_top_monitor
  import sfw_pkg::*;
(
  // Core clock and reset
  input wire logic              clk_i,
  input wire logic              arst_n_i,
  // Link and array ports
  input wire logic              cs_n_i,
  input wire logic              so_oe_o,
  input wire logic              mem_we_o,
  input wire logic [ADDR_W-1:0] mem_waddr_o,
  input wire logic              mem_erase_o,
  input wire logic [7:0]        mem_erase_map_o,
  // Status
  input wire logic [7:0]        status_o,
  input wire logic              busy_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);

  logic [2:0] lvl_q; // Protect level seen while idle
  logic       wel_q; // Write latch seen while idle

  // Own copy of the lock map, kept apart from the design's function
  function automatic logic [7:0] lock_of(input logic [2:0] l);
    return l[2] ? 8'hFF : (l == 3'h1) ? 8'h80 : (l == 3'h2) ? 8'hC0 : (l == 3'h3) ? 8'hF0 : 8'h00;
  endfunction

  // ==========================================================
  // Idle snapshot: status reads all ones during a cycle, so keep the last real value
  always_ff @(posedge clk_i or negedge arst_n_i)
    if (!arst_n_i)
    begin
      lvl_q <= 3'h0;
      wel_q <= 1'h0;
    end
    else if (!busy_o && status_o != 8'hFF)
    begin
      lvl_q <= status_o[4:2];
      wel_q <= status_o[1];
    end

  // ==========================================================
  // Properties
  busy_ones_a: assert property ($rose(busy_o) |-> ##[0:1] status_o == 8'hFF)
    else $error("status not all ones at start of cycle");
  idle_bits_a: assert property (!busy_o [*2] |-> status_o[6:5] == 2'h0 && !status_o[0])
    else $error("idle status shows busy or stray bits");
  end_clears_a: assert property ($fell(busy_o) |-> ##[0:1] status_o[1:0] == 2'h0)
    else $error("latch not cleared at end of cycle");
  write_busy_a: assert property (mem_we_o |-> ##[0:1] busy_o)
    else $error("array write outside a cycle");
  erase_busy_a: assert property (mem_erase_o |-> ##[0:1] busy_o)
    else $error("erase outside a cycle");
  write_unlocked_a: assert property (mem_we_o |-> (lock_of(lvl_q) & (8'h01 << mem_waddr_o[18:16])) == 8'h00)
    else $error("write into locked sector");
  erase_unlocked_a: assert property (mem_erase_o |-> (lock_of(lvl_q) & mem_erase_map_o) == 8'h00)
    else $error("erase touches locked sector");
  write_latch_a: assert property (mem_we_o |-> wel_q)
    else $error("write without latch");
  erase_latch_a: assert property (mem_erase_o |-> wel_q)
    else $error("erase without latch");
  so_quiet_a: assert property (cs_n_i |-> !so_oe_o)
    else $error("serial out driven while deselected");
endmodule

bind sfw_top sfw_top_monitor u_mon (
  .clk_i(clk_i), .arst_n_i(arst_n_i), .cs_n_i(cs_n_i), .so_oe_o(so_oe_o),
  .mem_we_o(mem_we_o), .mem_waddr_o(mem_waddr_o), .mem_erase_o(mem_erase_o),
  .mem_erase_map_o(mem_erase_map_o), .status_o(status_o), .busy_o(busy_o));
`default_nettype wire

// *** tb/sfw_spi_host.sv ***
// Behavioural SPI master, mode 0, 15 ns link clock made only inside frames.
// Assumes the bench fills tx before frame and reads rx afterwards.
`timescale 1ns/1ps
`default_nettype none
module sfw_spi_host (
  // Link outputs
  output var logic  sck_o,
  output var logic  cs_n_o,
  output var logic  si_o,
  // Link inputs
  input wire logic  so_i,
  input wire logic  so_oe_i
);
  logic [7:0] tx [0:299]; // Bytes to send
  logic [7:0] rx [0:299]; // Bytes captured
  logic       oe_seen;    // Device drove the line in this frame

  initial
  begin
    sck_o = 1'h0;
    cs_n_o = 1'h1;
    si_o = 1'h0;
  end

  // ==========================================================
  // One frame of n whole bytes; the clock stands low between frames
  task automatic frame(input int n);
    int i;
    int b;
    oe_seen = 1'h0;
    #3.1 cs_n_o = 1'h0;
    #7.5;
    for (i = 0; i < n; i++)
      for (b = 7; b >= 0; b--)
      begin
        si_o = tx[i][b];
        #7.5 sck_o = 1'h1;
        rx[i][b] = so_i;
        oe_seen = oe_seen | so_oe_i;
        #7.5 sck_o = 1'h0;
      end
    // Rise inside the low phase after the last bit, then toggle the data line
    #3 cs_n_o = 1'h1;
    si_o = ~si_o;
    #30;
  endtask
endmodule
`default_nettype wire

// *** tb/sfw_top_tb.sv ***
// Self-checking bench for the flash sequencer with a byte array model.
// Assumes shortened cycle counts and the SPI master model beside it.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin fail_count++; \
  $display("mismatch %s expected %h seen %h", nm, (ex), (got)); end end
module sfw_top_tb
  import sfw_pkg::*;
;
  logic              clk = 1'h0;
  logic              arst_n, wp_n, sck, cs_n, si, so, so_oe;
  logic              we, erase, busy;
  logic [ADDR_W-1:0] raddr, waddr, a;
  logic [7:0]        rdata, wdata, emap, status;
  logic [7:0]        mem [0:524287];     // Array model
  logic [7:0]        ref_mem [0:524287]; // Expected array
  logic [2:0]        lvl = 3'h0;         // Expected protect level
  logic              hpe = 1'h0;         // Expected protect enable
  logic [31:0]       seed = 32'd61853;
  int                fail_count = 0;
  int                n_tests = 0;

  always #2.5 clk = ~clk;

  sfw_top #(.PROG_CYCLES(4), .SECT_CYCLES(8), .CHIP_CYCLES(8), .SRWR_CYCLES(4)) dut (
    .clk_i(clk), .arst_n_i(arst_n), .sck_i(sck), .cs_n_i(cs_n), .si_i(si), .so_o(so),
    .so_oe_o(so_oe), .wp_n_i(wp_n), .mem_raddr_o(raddr), .mem_rdata_i(rdata),
    .mem_we_o(we), .mem_waddr_o(waddr), .mem_wdata_o(wdata), .mem_erase_o(erase),
    .mem_erase_map_o(emap), .status_o(status), .busy_o(busy));
  sfw_spi_host m (.sck_o(sck), .cs_n_o(cs_n), .si_o(si), .so_i(so), .so_oe_i(so_oe));

  // ==========================================================
  // Array model: combinational read, strobed write and sector erase
  assign rdata = mem[raddr];
  always @(posedge clk)
  begin
    if (we) mem[waddr] <= wdata;
    if (erase) for (int i = 0; i < 524288; i++) if (emap[i[18:16]]) mem[i] <= 8'hFF;
  end

  // ==========================================================
  // Expectation helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic locked(input logic [2:0] l, input logic [2:0] sec);
    return l[2] || (l == 3'h1 && sec == 3'h7) || (l == 3'h2 && sec >= 3'h6) || (l == 3'h3 && sec[2]);
  endfunction
  function automatic logic [7:0] stat_exp(input logic wel);
    return {hpe, 2'h0, lvl, wel, 1'h0};
  endfunction

  // ==========================================================
  // Frame tasks
  task automatic cmd(input logic [7:0] op);
    m.tx[0] = op;
    m.frame(1);
  endtask
  task automatic stat(input logic [7:0] ex);
    cmd(8'h05);
    m.tx[0] = 8'h05;
    m.frame(2);
    `CHK("status", ex, m.rx[1])
  endtask
  // Top address bits are random: the device must drop them
  task automatic hdr(input logic [7:0] op, input logic [18:0] ad);
    logic [31:0] r;
    r = rnd();
    m.tx[0] = op;
    m.tx[1] = {r[7:3], ad[18:16]};
    m.tx[2] = ad[15:8];
    m.tx[3] = ad[7:0];
  endtask
  task automatic wait_idle();
    int k;
    repeat (8) @(negedge clk);
    for (k = 0; k < 4000 && busy !== 1'h0; k++) @(negedge clk);
    `CHK("busy", 1'h0, busy)
  endtask
  task automatic rd(input logic [18:0] ad, input int n);
    int k;
    hdr(8'h0B, ad);
    for (k = 4; k < 4 + n; k++) m.tx[k] = 8'(rnd());
    m.frame(4 + n);
    for (k = 0; k < n; k++) `CHK("read byte", ref_mem[19'(ad + k)], m.rx[4 + k])
  endtask
  // Targets are erased first, so no byte is programmed twice
  task automatic prog(input logic [18:0] ad, input int n, input logic latch);
    int k;
    if (latch) cmd(8'h06);
    hdr(8'h0A, ad);
    for (k = 0; k < n; k++) m.tx[4 + k] = 8'(rnd());
    m.frame(4 + n);
    if (latch)
    begin
      stat(8'hFF);
      hdr(8'h03, ad);
      m.frame(5);
      `CHK("answer while busy", 1'h0, m.oe_seen)
      wait_idle();
      stat(stat_exp(1'h0));
      if (!locked(lvl, ad[18:16]))
        for (k = 0; k < n; k++) ref_mem[{ad[18:8], 8'(ad[7:0] + k)}] = m.tx[4 + k];
    end
  endtask
  task automatic ers(input logic [7:0] op, input logic [18:0] ad, input int n);
    int i;
    logic [7:0] map;
    map = (n == 1) ? 8'hFF : (8'h01 << ad[18:16]);
    cmd(8'h06);
    hdr(op, ad);
    m.frame(n);
    for (i = 0; i < 524288; i++) if (map[i[18:16]] && !locked(lvl, i[18:16])) ref_mem[i] = 8'hFF;
    wait_idle();
  endtask
  task automatic wsr(input logic [7:0] v);
    cmd(8'h06);
    m.tx[0] = 8'h09;
    m.tx[1] = v;
    m.frame(2);
    wait_idle();
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ==========================================================
  // Watchdog: far beyond the expected run of some 22000 cycles
  initial
  begin
    #400000;
    fail_count++;
    $display("mismatch watchdog expected done seen hang");
    summarize();
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    arst_n = 1'h0;
    wp_n = 1'h1;
    for (int i = 0; i < 524288; i++) mem[i] = 8'hFF;
    for (int i = 0; i < 524288; i++) ref_mem[i] = 8'hFF;
    repeat (4) @(negedge clk);
    arst_n = 1'h1;
    repeat (6) @(negedge clk);
    stat(8'h00);
    cmd(8'h0E);
    stat(8'h02);
    cmd(8'h0C);
    stat(8'h00);
    a = 19'(rnd());
    prog(a, 1, 1'h0);
    stat(8'h00);
    rd(a, 1);
    a = {3'(rnd() % 4), 8'(rnd()), 8'hFE};
    prog(a, 258, 1'h1);
    rd({a[18:8], 8'h00}, 256);
    wsr(8'h84);
    hpe = 1'h1;
    lvl = 3'h1;
    stat(stat_exp(1'h0));
    prog({3'h7, 16'h1234}, 2, 1'h1);
    rd({3'h7, 16'h1234}, 2);
    prog({3'h6, 16'h4321}, 2, 1'h1);
    rd({3'h6, 16'h4321}, 2);
    @(negedge clk) wp_n = 1'h0;
    repeat (4) @(negedge clk);
    wsr(8'h00);
    cmd(8'h04);
    stat(stat_exp(1'h0));
    ers(8'h5A, {3'h7, 16'h0000}, 4);
    cmd(8'h04);
    rd({3'h7, 16'h1234}, 2);
    ers(8'h52, {a[18:16], 16'(rnd())}, 4);
    rd(a, 4);
    @(negedge clk) wp_n = 1'h1;
    repeat (4) @(negedge clk);
    wsr(8'h08);
    hpe = 1'h0;
    lvl = 3'h2;
    stat(stat_exp(1'h0));
    @(negedge clk) wp_n = 1'h0;
    repeat (4) @(negedge clk);
    wsr(8'h0C);
    lvl = 3'h3;
    stat(stat_exp(1'h0));
    ers(8'h62, 19'h00000, 1);
    stat(stat_exp(1'h0));
    rd({3'h6, 16'h4321}, 2);
    for (int i = 0; i < 4; i++)
    begin
      a = {1'h0, i[1:0], 16'(rnd())};
      prog(a, 1 + int'(rnd() % 8), 1'h1);
      rd(a, 8);
    end
    rd(19'h7FFFF, 2);
    summarize();
  end
endmodule
`undef CHK
`default_nettype wire
